// >>> include/tsla_cfg.svh
// Layout constants for the texture surface layout addresser
`ifndef TSLA_CFG_SVH
`define TSLA_CFG_SVH

// Extra alignment units added to every slice pitch except stencil
`define TSLA_QPITCH_UNITS 8'h0B
// Texel rows packed into one compressed row, as a shift
`define TSLA_CMP_ROW_SHIFT 2'h2
// Extra rows the multisampled sampler slice shows
`define TSLA_ERRATA_ROWS 8'h04
// Faces in one cube
`define TSLA_CUBE_FACES 4'h6
// Alignment unit widths
`define TSLA_ALIGN_I_STD 4'h4
`define TSLA_ALIGN_I_WIDE 4'h8
// Alignment unit heights
`define TSLA_ALIGN_J_TWO 4'h2
`define TSLA_ALIGN_J_FOUR 4'h4

`endif

// >>> include/tsla_pkg.sv
// Types shared by the texture surface layout addresser
package tsla_pkg;

	// Surface arrangement of one request
	typedef enum logic [2:0] {
		tsla_kind_1d = 3'h0,
		tsla_kind_2d = 3'h1,
		tsla_kind_1d_arr = 3'h2,
		tsla_kind_2d_arr = 3'h3,
		tsla_kind_cube = 3'h4,
		tsla_kind_cube_arr = 3'h5,
		tsla_kind_3d = 3'h6,
		tsla_kind_stencil = 3'h7
	} tsla_kind_t;

	// Format class: plain, block_compressed_formats, eight_by_four_block_format
	typedef enum logic [1:0] {
		tsla_fmt_plain = 2'h0,
		tsla_fmt_block = 2'h1,
		tsla_fmt_eight_by_four = 2'h2
	} tsla_fmt_t;

endpackage

// >>> logic/tsla_level_size.sv
// Size of one mip level: raw, clamped and padded to the alignment unit
`timescale 1ns/1ns
`include "tsla_cfg.svh"

module tsla_level_size #(
	parameter int DIM_W = 14,
	parameter int COORD_W = 24,
	parameter int LVL_W = 4
) (
	input wire logic [DIM_W-1:0] base_w,
	input wire logic [DIM_W-1:0] base_h,
	input wire logic [DIM_W-1:0] base_d,
	input wire logic [LVL_W-1:0] mip_level,
	input wire logic msaa,
	input wire logic i_wide,
	input wire logic j_four,
	output logic [COORD_W-1:0] lvl_w,
	output logic [COORD_W-1:0] lvl_h,
	output logic [COORD_W-1:0] lvl_d,
	output logic [COORD_W-1:0] pad_w,
	output logic [COORD_W-1:0] pad_h
);

	logic [DIM_W-1:0] shr_w;
	logic [DIM_W-1:0] shr_h;
	logic [DIM_W-1:0] shr_d;
	logic [COORD_W-1:0] clamp_w;
	logic [COORD_W-1:0] clamp_h;
	logic [COORD_W-1:0] unit_i;
	logic [COORD_W-1:0] unit_j;

	// Halve per level, never below one texel
	assign shr_w = base_w >> mip_level;
	assign shr_h = base_h >> mip_level;
	assign shr_d = base_d >> mip_level;
	assign clamp_w = (shr_w == '0) ? COORD_W'(1) : COORD_W'(shr_w);
	assign clamp_h = (shr_h == '0) ? COORD_W'(1) : COORD_W'(shr_h);
	assign lvl_d = (shr_d == '0) ? COORD_W'(1) : COORD_W'(shr_d);

	// Multisampled levels grow to whole 2x2 sample groups
	assign lvl_w = msaa ? COORD_W'(((clamp_w + COORD_W'(1)) >> 1) << 2) : clamp_w;
	assign lvl_h = msaa ? COORD_W'(((clamp_h + COORD_W'(1)) >> 1) << 2) : clamp_h;

	// Round up to whole alignment units; depth is never padded
	assign unit_i = i_wide ? COORD_W'(`TSLA_ALIGN_I_WIDE) : COORD_W'(`TSLA_ALIGN_I_STD);
	assign unit_j = j_four ? COORD_W'(`TSLA_ALIGN_J_FOUR) : COORD_W'(`TSLA_ALIGN_J_TWO);
	assign pad_w = (lvl_w + unit_i - COORD_W'(1)) & ~(unit_i - COORD_W'(1));
	assign pad_h = (lvl_h + unit_j - COORD_W'(1)) & ~(unit_j - COORD_W'(1));

endmodule

// >>> logic/tsla_addresser.sv
// Texture surface layout addresser: slice, face, plane and level placement
//
// How it works
// - Slice row is slice pitch times index
// - Arrays and 1D always stack mips below
// - Plain slice pitch: h0 plus h1 plus 11j
// - Compressed slice pitch is that sum over four
// - Multisampled sampler slice adds four, some heights
// - Stencil slice pitch is padded h0 alone
// - Cube is six slices, faces in order
// - Cube layout fixed regardless of mips, faces
// - Cube array of N is 6N slices
// - Level size shifts by level, clamps at one
// - Pad width and height, never depth
// - Volume planes tile 2^L wide per level
// - Texel offset added onto level base
// - Outside texels unused; unmapped fetch faults
// - Data port never returns outside pixels
// - Below layout: one under, two right, down
// - Byte address from base, pitch, texel size
`timescale 1ns/1ns
`include "tsla_cfg.svh"

module tsla_addresser #(
	parameter int DIM_W = 14,
	parameter int COORD_W = 24,
	parameter int ADDR_W = 32,
	parameter int Q_W = 11,
	parameter int LVL_W = 4,
	parameter int MAX_LEVELS = 14
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire tsla_pkg::tsla_kind_t req_kind,
	input wire tsla_pkg::tsla_fmt_t req_fmt,
	input wire logic req_msaa,
	input wire logic req_sampler,
	input wire logic req_valign_four,
	input wire logic req_mip_layout_right,
	input wire logic [DIM_W-1:0] req_width,
	input wire logic [DIM_W-1:0] req_height,
	input wire logic [DIM_W-1:0] req_depth,
	input wire logic [LVL_W-1:0] req_mip_level,
	input wire logic [Q_W-1:0] req_index,
	input wire logic [2:0] req_face,
	input wire logic [DIM_W-1:0] req_x,
	input wire logic [DIM_W-1:0] req_y,
	input wire logic [ADDR_W-1:0] req_base,
	input wire logic [ADDR_W-1:0] req_pitch,
	input wire logic [4:0] req_half_bytes,
	input wire logic [ADDR_W-1:0] req_map_end,
	output logic resp_valid,
	input wire logic resp_ready,
	output logic [COORD_W-1:0] resp_base_x,
	output logic [COORD_W-1:0] resp_base_y,
	output logic [COORD_W-1:0] resp_qpitch,
	output logic [COORD_W-1:0] resp_row,
	output logic [ADDR_W-1:0] resp_addr,
	output logic [COORD_W-1:0] resp_lvl_w,
	output logic [COORD_W-1:0] resp_lvl_h,
	output logic [COORD_W-1:0] resp_pad_w,
	output logic [COORD_W-1:0] resp_pad_h,
	output logic resp_fault,
	output logic resp_deliver
);

	////////////////////////////////////////////////////////////////////////////////
	// Request decode

	logic accept;
	logic is_cmp;
	logic is_wide;
	logic is_stencil;
	logic is_3d;
	logic is_arrayed;
	logic use_below;
	logic j_four;
	logic errata_hit;
	logic [LVL_W-1:0] lvl_idx;
	logic [COORD_W-1:0] q_eff;

	assign accept = req_valid & req_ready;
	assign is_cmp = req_fmt != tsla_pkg::tsla_fmt_plain;
	assign is_wide = req_fmt == tsla_pkg::tsla_fmt_eight_by_four;
	assign is_stencil = req_kind == tsla_pkg::tsla_kind_stencil;
	assign is_3d = req_kind == tsla_pkg::tsla_kind_3d;
	assign is_arrayed = (req_kind == tsla_pkg::tsla_kind_1d_arr) ||
		(req_kind == tsla_pkg::tsla_kind_2d_arr) ||
		(req_kind == tsla_pkg::tsla_kind_cube) ||
		(req_kind == tsla_pkg::tsla_kind_cube_arr);
	// Layout mode only counts for plain 2D surfaces
	assign use_below = (req_kind != tsla_pkg::tsla_kind_2d) | ~req_mip_layout_right;
	// Compressed and multisampled need four-row units; stencil takes two
	assign j_four = is_cmp | (~is_stencil & (req_valign_four | req_msaa));
	// Heights 1, 5, 9, 13 ... hit the sampler slice pitch quirk
	assign errata_hit = req_msaa & req_sampler & (req_height[1:0] == 2'h1);
	assign lvl_idx = (req_mip_level > LVL_W'(MAX_LEVELS - 1)) ?
		LVL_W'(MAX_LEVELS - 1) : req_mip_level;

	// Slice number: cube face picks slice, cube array groups six per cube
	assign q_eff = (req_kind == tsla_pkg::tsla_kind_cube) ? COORD_W'(req_face) :
		(req_kind == tsla_pkg::tsla_kind_cube_arr) ?
		COORD_W'(COORD_W'(req_index) * COORD_W'(`TSLA_CUBE_FACES) + COORD_W'(req_face)) :
		COORD_W'(req_index);

	////////////////////////////////////////////////////////////////////////////////
	// Per-level sizes and running height sums

	logic [COORD_W-1:0] lvl_w_arr [0:MAX_LEVELS-1];
	logic [COORD_W-1:0] lvl_h_arr [0:MAX_LEVELS-1];
	logic [COORD_W-1:0] lvl_d_arr [0:MAX_LEVELS-1];
	logic [COORD_W-1:0] pad_w_arr [0:MAX_LEVELS-1];
	logic [COORD_W-1:0] pad_h_arr [0:MAX_LEVELS-1];
	logic [COORD_W-1:0] sum_h [0:MAX_LEVELS];
	logic [COORD_W-1:0] sum_v [0:MAX_LEVELS];

	assign sum_h[0] = '0;
	assign sum_v[0] = '0;

	// Prefix sums are exact integers; the only rounding is the plane ceiling
	for (genvar k = 0; k < MAX_LEVELS; k++) begin : g_lvl
		tsla_level_size #(
			.DIM_W(DIM_W),
			.COORD_W(COORD_W),
			.LVL_W(LVL_W)
		) u_size (
			.base_w(req_width),
			.base_h(req_height),
			.base_d(req_depth),
			.mip_level(LVL_W'(k)),
			.msaa(req_msaa),
			.i_wide(is_wide),
			.j_four(j_four),
			.lvl_w(lvl_w_arr[k]),
			.lvl_h(lvl_h_arr[k]),
			.lvl_d(lvl_d_arr[k]),
			.pad_w(pad_w_arr[k]),
			.pad_h(pad_h_arr[k])
		);
		assign sum_h[k+1] = sum_h[k] + pad_h_arr[k];
		assign sum_v[k+1] = sum_v[k] + COORD_W'(((lvl_d_arr[k] +
			COORD_W'((1 << k) - 1)) >> k) * pad_h_arr[k]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Level base coordinates

	logic [COORD_W-1:0] below_x;
	logic [COORD_W-1:0] below_y;
	logic [COORD_W-1:0] right_x;
	logic [COORD_W-1:0] right_y;
	logic [COORD_W-1:0] vol_x;
	logic [COORD_W-1:0] vol_y;
	logic [COORD_W-1:0] vol_mask;
	logic [COORD_W-1:0] base_x;
	logic [COORD_W-1:0] base_y;

	// Below: level 1 under level 0, level 2 right of 1, later ones down
	assign below_x = (lvl_idx >= LVL_W'(2)) ? pad_w_arr[1] : '0;
	assign below_y = (lvl_idx == '0) ? '0 :
		(lvl_idx == LVL_W'(1)) ? pad_h_arr[0] : sum_h[lvl_idx] - pad_h_arr[1];
	// Right: level 1 beside level 0, later ones stepped down
	assign right_x = (lvl_idx == '0) ? '0 : pad_w_arr[0];
	assign right_y = (lvl_idx <= LVL_W'(1)) ? '0 : sum_h[lvl_idx] - pad_h_arr[0];

	// Volume: planes of level L sit 2^L across under all earlier levels
	assign vol_mask = (COORD_W'(1) << lvl_idx) - COORD_W'(1);
	assign vol_x = COORD_W'((q_eff & vol_mask) * pad_w_arr[lvl_idx]);
	assign vol_y = COORD_W'(sum_v[lvl_idx] + (q_eff >> lvl_idx) * pad_h_arr[lvl_idx]);

	assign base_x = is_3d ? vol_x : use_below ? below_x : right_x;
	assign base_y = is_3d ? vol_y : use_below ? below_y : right_y;

	////////////////////////////////////////////////////////////////////////////////
	// Slice pitch

	logic [COORD_W-1:0] unit_j;
	logic [COORD_W-1:0] qp_sum;
	logic [COORD_W-1:0] qp_main;
	logic [COORD_W-1:0] qpitch;

	assign unit_j = j_four ? COORD_W'(`TSLA_ALIGN_J_FOUR) : COORD_W'(`TSLA_ALIGN_J_TWO);
	assign qp_sum = pad_h_arr[0] + pad_h_arr[1] +
		COORD_W'(COORD_W'(`TSLA_QPITCH_UNITS) * unit_j);
	// Compressed sum is a multiple of four, so the shift is exact
	assign qp_main = is_cmp ? (qp_sum >> `TSLA_CMP_ROW_SHIFT) : qp_sum;
	assign qpitch = is_stencil ? pad_h_arr[0] :
		errata_hit ? qp_main + COORD_W'(`TSLA_ERRATA_ROWS) : qp_main;

	////////////////////////////////////////////////////////////////////////////////
	// Memory row, byte address and fetch checks

	logic [COORD_W-1:0] tex_x;
	logic [COORD_W-1:0] tex_y;
	logic [COORD_W-1:0] slice_row;
	logic [COORD_W-1:0] row;
	logic [ADDR_W-1:0] x_bytes;
	logic [ADDR_W-1:0] addr;
	logic outside;
	logic fault;

	assign tex_x = base_x + COORD_W'(req_x);
	assign tex_y = base_y + COORD_W'(req_y);
	// Slice pitch is already in memory rows for compressed formats
	assign slice_row = (is_arrayed | is_stencil) ? COORD_W'(q_eff * qpitch) : '0;
	assign row = (is_cmp ? (tex_y >> `TSLA_CMP_ROW_SHIFT) : tex_y) + slice_row;
	// Half-byte texel size keeps four-bit formats exact
	assign x_bytes = is_cmp ? ADDR_W'((ADDR_W'(tex_x) * ADDR_W'(req_half_bytes)) << 1) :
		ADDR_W'((ADDR_W'(tex_x) * ADDR_W'(req_half_bytes)) >> 1);
	assign addr = ADDR_W'(req_base + ADDR_W'(row) * req_pitch + x_bytes);

	// Over-fetched texels are flagged unused; the mapping is still checked
	assign outside = (COORD_W'(req_x) >= lvl_w_arr[lvl_idx]) ||
		(COORD_W'(req_y) >= lvl_h_arr[lvl_idx]) ||
		(is_3d && (q_eff >= lvl_d_arr[lvl_idx]));
	// Relies on software mapping the padded extent; anything past it faults
	assign fault = addr >= req_map_end;

	////////////////////////////////////////////////////////////////////////////////
	// Output stage

	// One result held until taken; a new one may load as the old one leaves
	assign req_ready = ~resp_valid | resp_ready;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_valid <= 1'b0;
		end else if (req_ready) begin
			resp_valid <= req_valid;
		end
	end

	// Data registers load only on a taken request
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resp_base_x <= '0;
			resp_base_y <= '0;
			resp_qpitch <= '0;
			resp_row <= '0;
			resp_addr <= '0;
			resp_lvl_w <= '0;
			resp_lvl_h <= '0;
			resp_pad_w <= '0;
			resp_pad_h <= '0;
			resp_fault <= 1'b0;
			resp_deliver <= 1'b0;
		end else if (accept) begin
			resp_base_x <= base_x;
			resp_base_y <= base_y;
			resp_qpitch <= qpitch;
			resp_row <= row;
			resp_addr <= addr;
			resp_lvl_w <= lvl_w_arr[lvl_idx];
			resp_lvl_h <= lvl_h_arr[lvl_idx];
			resp_pad_w <= pad_w_arr[lvl_idx];
			resp_pad_h <= pad_h_arr[lvl_idx];
			resp_fault <= fault;
			resp_deliver <= ~outside;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	resp_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		resp_valid && !resp_ready |=> resp_valid && $stable(resp_addr))
		else $error("result changed while stalled");

	level_min_a: assert property (@(posedge clk) disable iff (!reset_n)
		resp_valid |-> (resp_lvl_w != '0) && (resp_lvl_h != '0))
		else $error("level size below one");

	pad_align_a: assert property (@(posedge clk) disable iff (!reset_n)
		resp_valid |-> (resp_pad_w[1:0] == 2'h0) && (resp_pad_h[0] == 1'b0) &&
		(resp_pad_h >= resp_lvl_h) && (resp_pad_w >= resp_lvl_w))
		else $error("level not padded to alignment unit");

	qpitch_plain_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && !is_cmp && !is_stencil && !errata_hit |=>
		resp_qpitch == $past(pad_h_arr[0] + pad_h_arr[1] + 11 * unit_j))
		else $error("plain slice pitch wrong");

	qpitch_cmp_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && is_cmp && !is_stencil && !errata_hit |=>
		resp_qpitch * 4 == $past(pad_h_arr[0] + pad_h_arr[1] + 11 * unit_j))
		else $error("compressed slice pitch wrong");

	qpitch_errata_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && !is_cmp && !is_stencil && errata_hit |=>
		resp_qpitch == $past(pad_h_arr[0] + pad_h_arr[1] + 11 * unit_j) + 4)
		else $error("multisample slice pitch quirk missing");

	stencil_qpitch_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && is_stencil |=> resp_qpitch == $past(pad_h_arr[0]))
		else $error("stencil slice pitch wrong");

	cube_slice_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (req_kind == tsla_pkg::tsla_kind_cube_arr) && !is_cmp &&
		(req_mip_level == '0) && (req_y == '0) |=>
		resp_row == COORD_W'(($past(req_index) * 6 + $past(req_face)) * resp_qpitch))
		else $error("cube array slice row wrong");

	array_below_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && is_arrayed && (req_mip_level == LVL_W'(1)) |=>
		(resp_base_x == '0) && (resp_base_y == $past(pad_h_arr[0])))
		else $error("array level one not below level zero");

	vol_plane_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && is_3d && (req_mip_level == '0) |=>
		(resp_base_x == '0) && (resp_base_y == COORD_W'($past(q_eff) * $past(pad_h_arr[0]))))
		else $error("volume level zero plane not stacked");

	fault_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept |=> resp_fault == (resp_addr >= $past(req_map_end)))
		else $error("translation fault flag wrong");

	deliver_a: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (COORD_W'(req_x) >= lvl_w_arr[lvl_idx]) |=> !resp_deliver)
		else $error("outside pixel delivered");

	cube_arr_c: cover property (@(posedge clk) disable iff (!reset_n)
		accept && (req_kind == tsla_pkg::tsla_kind_cube_arr) && (req_face == 3'h5));
	vol_level_c: cover property (@(posedge clk) disable iff (!reset_n)
		accept && is_3d && (req_mip_level == LVL_W'(2)));
	errata_c: cover property (@(posedge clk) disable iff (!reset_n)
		accept && errata_hit);
	fault_c: cover property (@(posedge clk) disable iff (!reset_n)
		resp_valid && resp_fault && !resp_deliver);

endmodule

// >>> testbench/tsla_mem_model.sv
// Memory side model: translated memory that takes results and counts translation errors
`timescale 1ns/1ns

module tsla_mem_model #(
	parameter logic [31:0] MAP_END = 32'h0001_0000
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic resp_valid,
	input wire logic resp_fault,
	output logic resp_ready,
	output logic [31:0] map_end,
	output logic [7:0] fault_cnt
);

	logic [1:0] phase_reg;

	////////////////////////////////////////////////////////////////////////
	// Mapped region ends at a fixed byte address
	// Covers the bench surfaces except the cube array rows, which land past it; past it is unmapped
	assign map_end = MAP_END;

	////////////////////////////////////////////////////////////////////////
	// Slow mode takes one result in four cycles, so results must wait
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_reg <= 2'h0;
			resp_ready <= 1'b1;
			fault_cnt <= 8'h00;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			resp_ready <= !slow || (phase_reg == 2'h2);
			// Fetch past the mapped pages is a translation error
			if (resp_valid && resp_ready && resp_fault) begin
				fault_cnt <= fault_cnt + 8'h01;
			end
		end
	end

endmodule

// >>> testbench/tsla_addresser_tb.sv
// Self-checking bench for the texture surface layout addresser
`timescale 1ns/1ns

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tsla_addresser_tb;

	typedef struct {
		tsla_pkg::tsla_kind_t k;
		tsla_pkg::tsla_fmt_t f;
		logic [3:0] fl;
		logic [13:0] w, h, d;
		logic [3:0] l;
		logic [10:0] i;
		logic [2:0] fc;
		logic [13:0] x, y;
		logic [23:0] q, row, bx, by;
		logic [31:0] a;
		logic [1:0] fd;
	} tsla_row_t;

	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic slow = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready, resp_valid, resp_ready, resp_fault, resp_deliver;
	tsla_pkg::tsla_kind_t req_kind = tsla_pkg::tsla_kind_2d;
	tsla_pkg::tsla_fmt_t req_fmt = tsla_pkg::tsla_fmt_plain;
	logic [3:0] req_flags = 4'h0;
	logic [13:0] req_width = 14'h1, req_height = 14'h1, req_depth = 14'h1;
	logic [13:0] req_x = 14'h0, req_y = 14'h0;
	logic [3:0] req_mip_level = 4'h0;
	logic [10:0] req_index = 11'h0;
	logic [2:0] req_face = 3'h0;
	logic [31:0] req_base = 32'h0000_1000;
	logic [31:0] req_pitch = 32'h0000_0100;
	logic [4:0] req_half_bytes = 5'h08;
	logic [23:0] resp_lvl_w, resp_lvl_h, resp_pad_w, resp_pad_h;
	logic [31:0] map_end, resp_addr;
	logic [23:0] resp_base_x, resp_base_y, resp_qpitch, resp_row;
	logic [7:0] fault_cnt;
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;
	tsla_row_t cr;

	// Flags are {msaa, sampler, valign four, right layout}; outcome is {fault, deliver}
	tsla_row_t rows [21] = '{
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h0A, 14'h1, 4'h0,
			11'h2, 3'h0, 14'h0, 14'h0, 24'h26, 24'h4C, 24'h0, 24'h0, 32'h5C00, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'h1, 14'h10, 14'h0A, 14'h1, 4'h1,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h26, 24'h0A, 24'h0, 24'h0A, 32'h1A00, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h0A, 14'h1, 4'h2,
			11'h1, 3'h0, 14'h0, 14'h0, 24'h26, 24'h30, 24'h8, 24'h0A, 32'h4020, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h0A, 14'h1, 4'h3,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h26, 24'h0C, 24'h8, 24'h0C, 32'h1C20, 2'h1},
		'{tsla_pkg::tsla_kind_2d, tsla_pkg::tsla_fmt_plain, 4'h1, 14'h10, 14'h0A, 14'h1, 4'h1,
			11'h2, 3'h0, 14'h0, 14'h0, 24'h0, 24'h0, 24'h10, 24'h0, 32'h1040, 2'h1},
		'{tsla_pkg::tsla_kind_1d, tsla_pkg::tsla_fmt_plain, 4'h1, 14'h10, 14'h1, 14'h1, 4'h1,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h0, 24'h2, 24'h0, 24'h2, 32'h1200, 2'h1},
		'{tsla_pkg::tsla_kind_2d, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h0A, 14'h1, 4'h0,
			11'h0, 3'h0, 14'h10, 14'h0, 24'h0, 24'h0, 24'h0, 24'h0, 32'h1040, 2'h0},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'h2, 14'h10, 14'h0A, 14'h1, 4'h0,
			11'h1, 3'h0, 14'h0, 14'h0, 24'h40, 24'h40, 24'h0, 24'h0, 32'h5000, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_block, 4'h0, 14'h10, 14'h10, 14'h1, 4'h0,
			11'h1, 3'h0, 14'h0, 14'h4, 24'h11, 24'h12, 24'h0, 24'h0, 32'h2200, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_eight_by_four, 4'h0, 14'h10, 14'h10, 14'h1,
			4'h0, 11'h0, 3'h0, 14'h8, 14'h0, 24'h11, 24'h0, 24'h0, 24'h0, 32'h1080, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'hC, 14'h10, 14'h5, 14'h1, 4'h0,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h40, 24'h0, 24'h0, 24'h0, 32'h1000, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'h8, 14'h10, 14'h5, 14'h1, 4'h0,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h3C, 24'h0, 24'h0, 24'h0, 32'h1000, 2'h1},
		'{tsla_pkg::tsla_kind_2d_arr, tsla_pkg::tsla_fmt_plain, 4'hC, 14'h10, 14'h7, 14'h1, 4'h0,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h44, 24'h0, 24'h0, 24'h0, 32'h1000, 2'h1},
		'{tsla_pkg::tsla_kind_cube, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h8, 14'h8, 14'h1, 4'h0,
			11'h0, 3'h5, 14'h0, 14'h0, 24'h22, 24'hAA, 24'h0, 24'h0, 32'hBA00, 2'h1},
		'{tsla_pkg::tsla_kind_cube_arr, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h8, 14'h8, 14'h1, 4'h0,
			11'h1, 3'h2, 14'h0, 14'h0, 24'h22, 24'h110, 24'h0, 24'h0, 32'h12000, 2'h3},
		'{tsla_pkg::tsla_kind_3d, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h8, 14'h4, 4'h1,
			11'h1, 3'h0, 14'h0, 14'h0, 24'h0, 24'h20, 24'h8, 24'h20, 32'h3020, 2'h1},
		'{tsla_pkg::tsla_kind_3d, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h8, 14'h4, 4'h1,
			11'h3, 3'h0, 14'h0, 14'h0, 24'h0, 24'h24, 24'h8, 24'h24, 32'h3420, 2'h0},
		'{tsla_pkg::tsla_kind_3d, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h8, 14'h4, 4'h2,
			11'h0, 3'h0, 14'h0, 14'h0, 24'h0, 24'h24, 24'h0, 24'h24, 32'h3400, 2'h1},
		'{tsla_pkg::tsla_kind_stencil, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h0A, 14'h1, 4'h0,
			11'h3, 3'h0, 14'h0, 14'h0, 24'h0A, 24'h1E, 24'h0, 24'h0, 32'h2E00, 2'h1},
		'{tsla_pkg::tsla_kind_3d, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h10, 14'h8, 14'h4, 4'h0,
			11'h2, 3'h0, 14'h0, 14'h0, 24'h0, 24'h10, 24'h0, 24'h10, 32'h2000, 2'h1},
		'{tsla_pkg::tsla_kind_cube_arr, tsla_pkg::tsla_fmt_plain, 4'h0, 14'h8, 14'h8, 14'h1, 4'h0,
			11'h1, 3'h2, 14'h8, 14'h0, 24'h22, 24'h110, 24'h0, 24'h0, 32'h12020, 2'h2}
	};

	////////////////////////////////////////////////////////////////////////
	// Clock, memory side and design
	always #2 clk = ~clk;

	tsla_mem_model tsla_mem_model_i (.clk(clk), .reset_n(reset_n), .slow(slow),
		.resp_valid(resp_valid), .resp_fault(resp_fault), .resp_ready(resp_ready),
		.map_end(map_end), .fault_cnt(fault_cnt));

	// Base, pitch and texel size start at four bytes a texel
	tsla_addresser tsla_addresser_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_kind(req_kind), .req_fmt(req_fmt), .req_msaa(req_flags[3]),
		.req_sampler(req_flags[2]), .req_valign_four(req_flags[1]),
		.req_mip_layout_right(req_flags[0]), .req_width(req_width), .req_height(req_height),
		.req_depth(req_depth), .req_mip_level(req_mip_level), .req_index(req_index),
		.req_face(req_face), .req_x(req_x), .req_y(req_y), .req_base(req_base),
		.req_pitch(req_pitch), .req_half_bytes(req_half_bytes), .req_map_end(map_end),
		.resp_valid(resp_valid), .resp_ready(resp_ready), .resp_base_x(resp_base_x),
		.resp_base_y(resp_base_y), .resp_qpitch(resp_qpitch), .resp_row(resp_row),
		.resp_addr(resp_addr), .resp_lvl_w(resp_lvl_w), .resp_lvl_h(resp_lvl_h),
		.resp_pad_w(resp_pad_w), .resp_pad_h(resp_pad_h),
		.resp_fault(resp_fault), .resp_deliver(resp_deliver));

	////////////////////////////////////////////////////////////////////////
	// Request driving, waiting and result comparison
	task automatic drive(input tsla_row_t r);
		req_kind = r.k;
		req_fmt = r.f;
		req_flags = r.fl;
		req_width = r.w;
		req_height = r.h;
		req_depth = r.d;
		req_mip_level = r.l;
		req_index = r.i;
		req_face = r.fc;
		req_x = r.x;
		req_y = r.y;
		req_valid = 1'b1;
	endtask

	// Hold the request until an edge takes it, then land on the next falling edge
	task automatic take;
		int n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		@(negedge clk);
	endtask

	// Slice pitch means nothing for plain and volume kinds
	task automatic check(input tsla_row_t r);
		`CHK(resp_valid, 1'b1);
		if (!(r.k inside {tsla_pkg::tsla_kind_1d, tsla_pkg::tsla_kind_2d, tsla_pkg::tsla_kind_3d}))
			`CHK(resp_qpitch, r.q);
		`CHK(resp_row, r.row);
		`CHK(resp_base_x, r.bx);
		`CHK(resp_base_y, r.by);
		`CHK(resp_addr, r.a);
		`CHK(resp_fault, r.fd[1]);
		`CHK(resp_deliver, r.fd[0]);
	endtask

	task automatic results;
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Table pass fast then stalled, then the awkward cases
	initial begin
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		`CHK(resp_valid, 1'b0);
		`CHK(req_ready, 1'b1);
		for (int p = 0; p < 2; p++) begin
			slow = p[0];
			for (int k = 0; k < 21; k++) begin
				drive(rows[k]);
				take();
				check(rows[k]);
			end
		end
		// Every face in order, one slice pitch apart
		slow = 1'b0;
		for (int f = 0; f < 6; f++) begin
			cr = rows[13];
			cr.fc = 3'(f);
			cr.row = 24'(f) * 24'h22;
			cr.a = 32'h1000 + 32'(f) * 32'h2200;
			drive(cr);
			take();
			check(cr);
		end
		req_valid = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(resp_valid, 1'b0);
		`CHK(fault_cnt, 8'h04);
		// Reset while a result waits on a stalled consumer
		slow = 1'b1;
		drive(rows[0]);
		take();
		`CHK(resp_valid, 1'b1);
		reset_n = 1'b0;
		#1;
		`CHK(resp_valid, 1'b0);
		`CHK(req_ready, 1'b1);
		@(negedge clk);
		req_valid = 1'b0;
		slow = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		drive(rows[14]);
		take();
		check(rows[14]);
		// Half-byte texels on a moved base and narrow pitch; level sizes too
		cr = rows[5];
		cr.k = tsla_pkg::tsla_kind_1d_arr;
		cr.w = 14'h0A;
		cr.i = 11'h1;
		cr.x = 14'h4;
		cr.q = 24'h1A;
		cr.row = 24'h1C;
		cr.a = 32'h2702;
		req_base = 32'h0000_2000;
		req_pitch = 32'h0000_0040;
		req_half_bytes = 5'h01;
		drive(cr);
		take();
		check(cr);
		`CHK(resp_lvl_w, 24'h5);
		`CHK(resp_lvl_h, 24'h1);
		`CHK(resp_pad_w, 24'h8);
		`CHK(resp_pad_h, 24'h2);
		results();
	end

endmodule
